// ---- logic/wcs_sequencer.sv ----
// wcs_sequencer: timed wash sequencer with an AXI4-Lite register port
// assumes valves, pumps and dispensers follow the outputs directly and the
// pressure switch input is synchronous to CLK_SYS
// Notes on behaviour
// - acid dispenses its programmed 0-10 min regardless of fill or circulation
// - final rinse water: 0 opens cold only, 2 opens hot
// - acid waits 10, 30 or 60 s by code 0, 1, 2
// - final rinse circulates for programmed 0-10 min in seconds
// - final rinse purge: vacuum pump, diverter and drain for 0-3 min
// - sanitizer dispenses its programmed 0-10 min regardless of fill state
// - sanitize water: 0 cold, 1 hot and cold, 2 hot
// - sanitizer waits 10, 30, 60 s, or code 3 until air delay elapsed
// - sanitize circulates for programmed 0-10 min in seconds
// - sanitize purge: vacuum pump, diverter and drain for 0-5 min
// - four fill limits: rinse, wash, final rinse, sanitize; up to 15 min
// - circulation starts on pressure switch or when fill limit expires
// - optional extra water during diverted initial rinse, rinse temperature
// - optional extra water after initial rinse divert, rinse temperature
// - optional extra water after wash circulation start, wash temperature
// - optional extra water after final rinse circulation start
// - optional extra water after sanitize circulation start
// - continuous milk option runs the pump once air delay elapsed
// - reversal option inverts the divert output in every state
// - skip-stop 0 stops after final rinse; 1 goes straight to sanitize
// - cycles run rinse, wash, repeated wash, final rinse, sanitize
// - continuous vacuum runs the pump throughout, off in the final pause
// - air delay counts 0-60 s from circulation start
module wcs_sequencer #(
	parameter int TICK_CYCLES = wcs_pkg::TICK_CYCLES
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic PRESS_SW,
	output logic VALVE_HOT,
	output logic VALVE_COLD,
	output logic DISP_DET,
	output logic DISP_ACID,
	output logic DISP_SAN,
	output logic DIVERT_OUT,
	output logic DRAIN_OUT,
	output logic MILK_PUMP,
	output logic VACUUM_PUMP_OUTPUT
);
	import wcs_pkg::*;

	logic tick;
	logic [OPT_W-1:0] opt_r;
	logic [TW-1:0] tim_r [NTIM];
	logic bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic wr_take, rd_take, wr_tim, rd_tim;
	logic [5:0] wr_word, rd_word, wr_idx, rd_idx;
	logic start_wash, start_san, abort_p;
	wcs_cycle_t cyc_r, follow_cyc;
	wcs_phase_t ph_r;
	logic [TW-1:0] sec_r, circ_sec_r, cyc_sec_r, chem_run_r;
	logic circ_on_r;
	logic [1:0] temp, dcode;
	logic [TW-1:0] ctime, xw, lim, dur, dly_s, xw_cnt;
	logic done, cyc_start, last_cyc, air_ok, chem_go, chem_on, xw_on;
	logic hot_raw, cold_raw, div_raw, drain_raw, milk_raw, vac_raw;
	logic [8:0] outs;

	wcs_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.tick(tick)
	);

	// register writes: address and data are taken together
	assign wr_take = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_r;
	assign S_AXI_AWREADY = wr_take;
	assign S_AXI_WREADY = wr_take;
	assign wr_word = S_AXI_AWADDR[7:2];
	assign wr_idx = wr_word - ADDR_TIM0[7:2];
	assign wr_tim = wr_word >= ADDR_TIM0[7:2] && wr_idx < 6'(NTIM);
	assign start_wash = wr_take && wr_word == ADDR_CTRL[7:2]
		&& S_AXI_WSTRB[0] && S_AXI_WDATA[CTRL_START_WASH];
	assign start_san = wr_take && wr_word == ADDR_CTRL[7:2]
		&& S_AXI_WSTRB[0] && S_AXI_WDATA[CTRL_START_SAN];
	assign abort_p = wr_take && wr_word == ADDR_CTRL[7:2]
		&& S_AXI_WSTRB[0] && S_AXI_WDATA[CTRL_ABORT];

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			opt_r <= OPT_RST;
		end else if (wr_take && wr_word == ADDR_OPT[7:2]) begin
			if (S_AXI_WSTRB[0]) opt_r[7:0] <= S_AXI_WDATA[7:0];
			if (S_AXI_WSTRB[1]) opt_r[15:8] <= S_AXI_WDATA[15:8];
			if (S_AXI_WSTRB[2]) opt_r[18:16] <= S_AXI_WDATA[18:16];
		end
	end

	// timer table, each entry clamped to its allowed range
	for (genvar i = 0; i < NTIM; i++) begin : g_tim
		logic [TW-1:0] merged;
		always_comb begin
			merged = tim_r[i];
			if (S_AXI_WSTRB[0]) merged[7:0] = S_AXI_WDATA[7:0];
			if (S_AXI_WSTRB[1]) merged[TW-1:8] = S_AXI_WDATA[TW-1:8];
		end
		always_ff @(posedge CLK_SYS) begin
			if (!RST_N) begin
				tim_r[i] <= '0;
			end else if (wr_take && wr_tim && wr_idx == 6'(i)) begin
				tim_r[i] <= (merged > TIM_MAX[i]) ? TIM_MAX[i] : merged;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (wr_take) begin
			bvalid_r <= 1'b1;
			bresp_r <= (wr_word == ADDR_CTRL[7:2] || wr_word == ADDR_OPT[7:2]
				|| wr_tim) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;

	// register reads, one cycle after the address is taken
	assign rd_take = S_AXI_ARVALID && !rvalid_r;
	assign S_AXI_ARREADY = !rvalid_r;
	assign rd_word = S_AXI_ARADDR[7:2];
	assign rd_idx = rd_word - ADDR_TIM0[7:2];
	assign rd_tim = rd_word >= ADDR_TIM0[7:2] && rd_idx < 6'(NTIM);

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else if (rd_take) begin
			rvalid_r <= 1'b1;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h00000000;
			if (rd_word == ADDR_OPT[7:2]) begin
				rdata_r[OPT_W-1:0] <= opt_r;
			end else if (rd_word == ADDR_STAT[7:2]) begin
				rdata_r[STAT_PHASE+:3] <= ph_r;
				rdata_r[STAT_CYCLE+:3] <= cyc_r;
				rdata_r[STAT_PRESS] <= PRESS_SW;
				rdata_r[STAT_OUTS+:9] <= outs;
			end else if (rd_tim) begin
				rdata_r[TW-1:0] <= tim_r[rd_idx[4:0]];
			end else if (rd_word != ADDR_CTRL[7:2]) begin
				rresp_r <= RESP_SLVERR;
			end
		end else if (S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;

	// per-cycle settings
	always_comb begin
		temp = TEMP_COLD;
		dcode = 2'h0;
		ctime = '0;
		xw = '0;
		lim = '0;
		case (cyc_r)
			CY_RINSE: begin
				temp = opt_r[OPT_RINSE_TEMP+:2];
				lim = tim_r[TI_FILL_IR];
				xw = (ph_r == PH_CDIV) ? tim_r[TI_XW_IR_DIV]
					: tim_r[TI_XW_IR_AFT];
			end
			CY_WASH, CY_WASH2: begin
				temp = opt_r[OPT_WASH_TEMP+:2];
				dcode = opt_r[OPT_WASH_DLY+:2];
				ctime = tim_r[TI_DET];
				xw = tim_r[TI_XW_WASH];
				lim = tim_r[TI_FILL_WASH];
			end
			CY_FINAL: begin
				temp = opt_r[OPT_FR_TEMP+:2];
				dcode = opt_r[OPT_FR_DLY+:2];
				ctime = tim_r[TI_ACID];
				xw = tim_r[TI_XW_FR];
				lim = tim_r[TI_FILL_FR];
			end
			CY_SAN: begin
				temp = opt_r[OPT_SAN_TEMP+:2];
				dcode = opt_r[OPT_SAN_DLY+:2];
				ctime = tim_r[TI_SAN];
				xw = tim_r[TI_XW_SAN];
				lim = tim_r[TI_FILL_SAN];
			end
			default: ;
		endcase
	end

	// phase duration and cycle order
	always_comb begin
		dur = '0;
		case (ph_r)
			PH_FILL: dur = lim;
			PH_CDIV: dur = (cyc_r == CY_RINSE) ? tim_r[TI_IR_DIV]
				: tim_r[TI_WASH_DIV];
			PH_CIRC: begin
				case (cyc_r)
					CY_RINSE: dur = tim_r[TI_IR_AFT];
					CY_FINAL: dur = tim_r[TI_FR_CIRC];
					CY_SAN: dur = tim_r[TI_SAN_CIRC];
					default: dur = tim_r[TI_WASH_CIRC];
				endcase
			end
			PH_DRAIN: dur = (cyc_r == CY_RINSE) ? tim_r[TI_IR_DRAIN]
				: tim_r[TI_DRAIN];
			PH_PURGE: begin
				case (cyc_r)
					CY_FINAL: dur = tim_r[TI_FR_PURGE];
					CY_SAN: dur = tim_r[TI_SAN_PURGE];
					default: dur = tim_r[TI_WASH_PURGE];
				endcase
			end
			PH_PAUSE: dur = (cyc_r == CY_WASH || cyc_r == CY_WASH2)
				? tim_r[TI_WASH_PAUSE] : tim_r[TI_PAUSE];
			default: dur = '0;
		endcase
		case (cyc_r)
			CY_RINSE: follow_cyc = CY_WASH;
			CY_WASH: follow_cyc = opt_r[OPT_REPEAT] ? CY_WASH2 : CY_FINAL;
			CY_WASH2: follow_cyc = CY_FINAL;
			CY_FINAL: follow_cyc = opt_r[OPT_SKIP_STOP] ? CY_SAN
				: CY_IDLE;
			default: follow_cyc = CY_IDLE;
		endcase
	end

	// fill ends on the pressure switch or on the limit
	assign done = (ph_r == PH_FILL) ? (PRESS_SW || sec_r >= lim)
		: (sec_r >= dur);
	assign last_cyc = (follow_cyc == CY_IDLE);
	assign cyc_start = (ph_r == PH_IDLE && (start_wash || start_san))
		|| (ph_r == PH_PAUSE && done && !last_cyc);

	// sequencer; sec_r counts whole seconds within the phase
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ph_r <= PH_IDLE;
			cyc_r <= CY_IDLE;
			sec_r <= '0;
		end else begin
			if (tick && sec_r != '1) sec_r <= sec_r + 1'b1;
			if (abort_p) begin
				ph_r <= PH_IDLE;
				cyc_r <= CY_IDLE;
				sec_r <= '0;
			end else begin
				case (ph_r)
					PH_IDLE: begin
						if (start_wash || start_san) begin
							ph_r <= PH_FILL;
							cyc_r <= start_wash ? CY_RINSE : CY_SAN;
							sec_r <= '0;
						end
					end
					PH_FILL: begin
						if (done) begin
							ph_r <= (cyc_r == CY_RINSE || cyc_r == CY_WASH
								|| cyc_r == CY_WASH2) ? PH_CDIV : PH_CIRC;
							sec_r <= '0;
						end
					end
					PH_CDIV, PH_CIRC, PH_DRAIN, PH_PURGE: begin
						if (done) begin
							sec_r <= '0;
							if (ph_r == PH_CDIV) ph_r <= PH_CIRC;
							else if (ph_r == PH_CIRC) ph_r <= PH_DRAIN;
							else if (ph_r == PH_PURGE || cyc_r == CY_RINSE)
								ph_r <= PH_PAUSE;
							else ph_r <= PH_PURGE;
						end
					end
					PH_PAUSE: begin
						if (done) begin
							ph_r <= last_cyc ? PH_IDLE : PH_FILL;
							cyc_r <= follow_cyc;
							sec_r <= '0;
						end
					end
					default: ph_r <= PH_IDLE;
				endcase
			end
		end
	end

	// cycle timers: since cycle start, since circulation start, dispensing
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || cyc_start || abort_p) begin
			circ_on_r <= 1'b0;
			circ_sec_r <= '0;
			cyc_sec_r <= '0;
			chem_run_r <= '0;
		end else begin
			if (ph_r == PH_FILL && done) circ_on_r <= 1'b1;
			if (tick && circ_on_r && circ_sec_r != '1)
				circ_sec_r <= circ_sec_r + 1'b1;
			if (tick && cyc_sec_r != '1) cyc_sec_r <= cyc_sec_r + 1'b1;
			if (tick && chem_on) chem_run_r <= chem_run_r + 1'b1;
		end
	end

	assign air_ok = circ_on_r && circ_sec_r >= tim_r[TI_AIR_DLY];
	always_comb begin
		case (dcode)
			2'h0: dly_s = DLY0_S;
			2'h1: dly_s = DLY1_S;
			default: dly_s = DLY2_S;
		endcase
	end
	// wash code 3 waits for the divert, sanitize code 3 for air start
	assign chem_go = (dcode != DLY_AFTER) ? cyc_sec_r >= dly_s
		: (cyc_r == CY_WASH || cyc_r == CY_WASH2)
		? (circ_on_r && ph_r != PH_CDIV) : air_ok;
	// dispensing ignores fill and circulation state
	assign chem_on = ph_r != PH_IDLE && chem_go && chem_run_r < ctime;

	assign xw_cnt = (cyc_r == CY_RINSE) ? sec_r : circ_sec_r;
	assign xw_on = (ph_r == PH_CDIV || ph_r == PH_CIRC) && xw_cnt < xw;

	always_comb begin
		hot_raw = 1'b0;
		cold_raw = 1'b0;
		if (ph_r == PH_FILL || xw_on) begin
			hot_raw = temp == TEMP_HOT || temp == TEMP_TEMPERED;
			cold_raw = temp != TEMP_HOT;
		end
		div_raw = ph_r == PH_CDIV || ph_r == PH_DRAIN || ph_r == PH_PURGE
			|| ph_r == PH_PAUSE;
		drain_raw = ph_r == PH_DRAIN || ph_r == PH_PURGE
			|| ph_r == PH_PAUSE;
		milk_raw = ph_r == PH_DRAIN || (opt_r[OPT_MILK_CONT] && air_ok
			&& (ph_r == PH_CDIV || ph_r == PH_CIRC));
		vac_raw = ph_r == PH_CDIV || ph_r == PH_CIRC || ph_r == PH_DRAIN
			|| ph_r == PH_PURGE;
		if (opt_r[OPT_VAC_CONT] && ph_r != PH_IDLE
			&& !(ph_r == PH_PAUSE && last_cyc))
			vac_raw = 1'b1;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			outs <= '0;
		end else begin
			outs <= {vac_raw, milk_raw, drain_raw,
				div_raw ^ opt_r[OPT_DIV_REV],
				chem_on && cyc_r == CY_SAN, chem_on && cyc_r == CY_FINAL,
				chem_on && (cyc_r == CY_WASH || cyc_r == CY_WASH2),
				cold_raw, hot_raw};
		end
	end
	assign {VACUUM_PUMP_OUTPUT, MILK_PUMP, DRAIN_OUT, DIVERT_OUT, DISP_SAN,
		DISP_ACID, DISP_DET, VALVE_COLD, VALVE_HOT} = outs;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	sequence s_fill_ends;
		ph_r == PH_FILL && !abort_p && (PRESS_SW || sec_r >= lim);
	endsequence
	a_fill_to_circ: assert property (s_fill_ends |=> ph_r == PH_CDIV
		|| ph_r == PH_CIRC) else $error("fill did not start circulation");
	a_fill_holds: assert property (ph_r == PH_FILL && !PRESS_SW
		&& sec_r < lim && !abort_p |=> ph_r == PH_FILL)
		else $error("fill left before limit");
	a_purge_outs: assert property (ph_r == PH_PURGE && !opt_r[OPT_DIV_REV]
		|=> VACUUM_PUMP_OUTPUT && DRAIN_OUT && DIVERT_OUT)
		else $error("purge outputs wrong");
	a_divert_rev: assert property (ph_r == PH_IDLE && opt_r[OPT_DIV_REV]
		|=> DIVERT_OUT) else $error("divert not inverted");
	a_acid_hold: assert property (cyc_r == CY_FINAL && dcode == 2'h0
		&& cyc_sec_r < DLY0_S |=> !DISP_ACID) else $error("acid too early");
	a_acid_run: assert property (cyc_r == CY_FINAL && chem_go
		&& chem_run_r < ctime && ph_r != PH_IDLE |=> DISP_ACID)
		else $error("acid stopped early");
	a_san_temper: assert property (cyc_r == CY_SAN && ph_r == PH_FILL
		&& temp == TEMP_TEMPERED |=> VALVE_HOT && VALVE_COLD)
		else $error("tempered water wrong");
	a_final_cold: assert property (cyc_r == CY_FINAL && ph_r == PH_FILL
		&& temp == TEMP_COLD |=> VALVE_COLD && !VALVE_HOT)
		else $error("cold rinse wrong");
	a_skip_stop: assert property (cyc_r == CY_FINAL && ph_r == PH_PAUSE
		&& done && !abort_p |=> cyc_r == (opt_r[OPT_SKIP_STOP] ? CY_SAN
		: CY_IDLE)) else $error("wrong cycle after final rinse");
	a_vac_cont: assert property (opt_r[OPT_VAC_CONT] && ph_r == PH_FILL
		|=> VACUUM_PUMP_OUTPUT) else $error("vacuum not continuous");
	a_vac_rest: assert property (opt_r[OPT_VAC_CONT] && ph_r == PH_PAUSE
		&& last_cyc |=> !VACUUM_PUMP_OUTPUT)
		else $error("vacuum on in final pause");
	a_sec_step: assert property (!tick && !done && !abort_p
		&& ph_r != PH_IDLE |=> sec_r == $past(sec_r))
		else $error("phase timer moved off tick");
endmodule

// ---- logic/wcs_pkg.sv ----
// wcs_pkg: constants, register map and state types of the wash sequencer
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register port
package wcs_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SEC_NS = 1_000_000_000;
	localparam int TICK_CYCLES = SEC_NS / CLK_PERIOD_NS;
	localparam int SEC_PER_MIN = 60;
	localparam int TW = 10;
	localparam int NTIM = 26;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_OPT = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_TIM0 = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// control register bits (write pulses, read as zero)
	localparam int CTRL_START_WASH = 0;
	localparam int CTRL_START_SAN = 1;
	localparam int CTRL_ABORT = 2;

	// option register fields
	localparam int OPT_W = 19;
	localparam logic [OPT_W-1:0] OPT_RST = 19'h00000;
	localparam int OPT_RINSE_TEMP = 0;
	localparam int OPT_WASH_TEMP = 2;
	localparam int OPT_FR_TEMP = 4;
	localparam int OPT_SAN_TEMP = 6;
	localparam int OPT_WASH_DLY = 8;
	localparam int OPT_FR_DLY = 10;
	localparam int OPT_SAN_DLY = 12;
	localparam int OPT_MILK_CONT = 14;
	localparam int OPT_DIV_REV = 15;
	localparam int OPT_SKIP_STOP = 16;
	localparam int OPT_VAC_CONT = 17;
	localparam int OPT_REPEAT = 18;

	// status register fields
	localparam int STAT_PHASE = 0;
	localparam int STAT_CYCLE = 4;
	localparam int STAT_PRESS = 8;
	localparam int STAT_OUTS = 16;

	localparam logic [1:0] TEMP_COLD = 2'h0;
	localparam logic [1:0] TEMP_TEMPERED = 2'h1;
	localparam logic [1:0] TEMP_HOT = 2'h2;
	localparam logic [1:0] DLY_AFTER = 2'h3;
	localparam logic [TW-1:0] DLY0_S = 10'h00A;
	localparam logic [TW-1:0] DLY1_S = 10'h01E;
	localparam logic [TW-1:0] DLY2_S = 10'h03C;

	// timer table indices, one word each from ADDR_TIM0
	localparam int TI_AIR_DLY = 0;
	localparam int TI_IR_DIV = 1;
	localparam int TI_IR_AFT = 2;
	localparam int TI_IR_DRAIN = 3;
	localparam int TI_PAUSE = 4;
	localparam int TI_WASH_DIV = 5;
	localparam int TI_WASH_CIRC = 6;
	localparam int TI_DRAIN = 7;
	localparam int TI_WASH_PURGE = 8;
	localparam int TI_WASH_PAUSE = 9;
	localparam int TI_DET = 10;
	localparam int TI_ACID = 11;
	localparam int TI_FR_CIRC = 12;
	localparam int TI_FR_PURGE = 13;
	localparam int TI_SAN = 14;
	localparam int TI_SAN_CIRC = 15;
	localparam int TI_SAN_PURGE = 16;
	localparam int TI_FILL_IR = 17;
	localparam int TI_FILL_WASH = 18;
	localparam int TI_FILL_FR = 19;
	localparam int TI_FILL_SAN = 20;
	localparam int TI_XW_IR_DIV = 21;
	localparam int TI_XW_IR_AFT = 22;
	localparam int TI_XW_WASH = 23;
	localparam int TI_XW_FR = 24;
	localparam int TI_XW_SAN = 25;

	// upper limit of each timer in seconds; writes above it are clamped
	localparam logic [TW-1:0] TIM_MAX [NTIM] = '{
		TW'(SEC_PER_MIN), TW'(8 * SEC_PER_MIN), TW'(4 * SEC_PER_MIN),
		TW'(6 * SEC_PER_MIN), TW'(5 * SEC_PER_MIN), TW'(3 * SEC_PER_MIN),
		TW'(15 * SEC_PER_MIN), TW'(6 * SEC_PER_MIN), TW'(3 * SEC_PER_MIN),
		TW'(5 * SEC_PER_MIN), TW'(10 * SEC_PER_MIN), TW'(10 * SEC_PER_MIN),
		TW'(10 * SEC_PER_MIN), TW'(3 * SEC_PER_MIN), TW'(10 * SEC_PER_MIN),
		TW'(10 * SEC_PER_MIN), TW'(5 * SEC_PER_MIN), TW'(15 * SEC_PER_MIN),
		TW'(15 * SEC_PER_MIN), TW'(15 * SEC_PER_MIN), TW'(15 * SEC_PER_MIN),
		TW'(4 * SEC_PER_MIN), TW'(4 * SEC_PER_MIN), TW'(6 * SEC_PER_MIN),
		TW'(6 * SEC_PER_MIN), TW'(6 * SEC_PER_MIN)};

	typedef enum logic [2:0] {
		CY_IDLE, CY_RINSE, CY_WASH, CY_WASH2, CY_FINAL, CY_SAN
	} wcs_cycle_t;
	typedef enum logic [2:0] {
		PH_IDLE, PH_FILL, PH_CDIV, PH_CIRC, PH_DRAIN, PH_PURGE, PH_PAUSE
	} wcs_phase_t;
endpackage

// ---- logic/wcs_tick.sv ----
// wcs_tick: one-cycle enable pulse once every CYCLES system clocks
// assumes a synchronous active-low reset on the same clock
module wcs_tick #(
	parameter int CYCLES = 50_000_000
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);
	localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	logic [W-1:0] cnt_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (cnt_r == W'(CYCLES - 1)) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign tick = (cnt_r == W'(CYCLES - 1));
endmodule

// ---- dv/wcs_plant.sv ----
// wcs_plant: wash vat with fill pressure switch beside the sequencer
// assumes the valve and drain inputs are registered outputs on clk
module wcs_plant (
	input wire logic clk,
	input wire logic valve_hot,
	input wire logic valve_cold,
	input wire logic drain,
	input wire logic broken,
	input wire logic [7:0] need,
	output logic press_sw
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] level_r = 8'h00;
	// vat level rises while any fill valve is open, empties on drain
	always_ff @(posedge clk) begin
		if (drain)
			level_r <= 8'h00;
		else if ((valve_hot || valve_cold) && level_r != 8'hFF)
			level_r <= level_r + 8'h01;
	end
	// a failed switch never closes
	assign press_sw = !broken && level_r >= need;
endmodule

// ---- dv/wcs_sequencer_bench.sv ----
// wcs_sequencer_bench: self-checking bench for the wash sequencer
// assumes a short tick of TK clocks and the plant model on PRESS_SW
module wcs_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import wcs_pkg::*;
	localparam int TK = 8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic broken = 1'b0;
	logic [7:0] need = 8'h20;
	logic awready, wready, bvalid, arready, rvalid, press;
	logic [1:0] bresp, rresp, wresp;
	logic [31:0] rdata;
	logic hot, cold, det, acid, san, div, drn, milk, vac;
	logic [8:0] outs;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	assign outs = {vac, milk, drn, div, san, acid, det, cold, hot};
	always #10 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	wcs_sequencer #(.TICK_CYCLES(TK)) u_wcs_sequencer (
		.CLK_SYS(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .PRESS_SW(press),
		.VALVE_HOT(hot), .VALVE_COLD(cold), .DISP_DET(det),
		.DISP_ACID(acid), .DISP_SAN(san), .DIVERT_OUT(div),
		.DRAIN_OUT(drn), .MILK_PUMP(milk), .VACUUM_PUMP_OUTPUT(vac));
	wcs_plant u_wcs_plant (.clk(clk), .valve_hot(hot), .valve_cold(cold),
		.drain(drn), .broken(broken), .need(need), .press_sw(press));

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk); while (!bvalid);
		wresp = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic tim(input int i, input int s);
		wr(8'(ADDR_TIM0 + 4 * i), 32'(s));
	endtask
	// poll status until the masked fields match, then compare
	task automatic wstat(input logic [31:0] m, input logic [31:0] v);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		do begin
			rd(ADDR_STAT, d, r);
			n++;
		end while ((d & m) !== v && n < 4000);
		chk(d & m, v);
	endtask
	task automatic wout(input logic [8:0] m, input logic [8:0] v,
		output int t);
		int n;
		n = 0;
		while ((outs & m) !== v && n < 4000) begin
			@(posedge clk);
			n++;
		end
		t = cyc;
		chk(32'(outs & m), 32'(v));
	endtask
	// expected {cold, hot} for a water temperature code
	function automatic logic [1:0] water(input int c);
		return c == 1 ? 2'h3 : c == 2 ? 2'h1 : 2'h2;
	endfunction
	function automatic int dly(input int c);
		return c == 0 ? 10 : c == 1 ? 30 : 60;
	endfunction
	function automatic logic [31:0] inr(input int v, input int lo,
		input int hi);
		return 32'(v >= lo && v <= hi);
	endfunction

	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		results();
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int t0, t1, t2, c, s, k;
		void'($urandom(99748));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(32'(outs), 32'h0);
		rd(ADDR_OPT, d, r);
		chk(d, 32'h0);
		rd(8'h0C, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(8'h0C, 32'h0);
		chk(32'(wresp), 32'(RESP_SLVERR));
		rd(ADDR_TIM0, d, r);
		chk(d, 32'h0);
		tim(TI_AIR_DLY, 1000);
		rd(ADDR_TIM0, d, r);
		chk(d, 32'h3C);
		tim(TI_AIR_DLY, 0);
		wr(ADDR_OPT, 32'h8000);
		chk(32'(wresp), 32'(RESP_OKAY));
		repeat (2) @(posedge clk);
		chk(32'(div), 32'h1);
		wr(ADDR_OPT, 32'h0);
		repeat (2) @(posedge clk);
		chk(32'(div), 32'h0);
		$display("test reset and reversal done");
		tim(TI_SAN_CIRC, 100);
		tim(TI_SAN_PURGE, 3);
		tim(TI_PAUSE, 1);
		tim(TI_FILL_SAN, 40);
		for (c = 0; c < 3; c++) begin
			k = $urandom_range(2);
			s = $urandom_range(4, 1);
			need <= 8'($urandom_range(60, 24));
			tim(TI_SAN, s);
			wr(ADDR_OPT, 32'(c << OPT_SAN_TEMP | k << OPT_SAN_DLY));
			wr(ADDR_CTRL, 32'h2);
			t0 = cyc;
			wstat(32'h77, 32'h51);
			chk(32'(outs[1:0]), 32'(water(c)));
			wstat(32'h7, 32'h3);
			chk(inr(cyc - t0, 0, 10 * TK), 1);
			wout(9'h010, 9'h010, t1);
			chk(inr(t1 - t0, (dly(k) - 1) * TK - 6, dly(k) * TK + 4), 1);
			wout(9'h010, 9'h000, t2);
			chk(inr(t2 - t1, (s - 1) * TK, s * TK + 4), 1);
			wstat(32'h7, 32'h5);
			chk(32'(outs[8:5]), 32'hB);
			wstat(32'h77, 32'h0);
			$display("test sanitize %0d done", c);
		end
		broken <= 1'b1;
		tim(TI_FILL_SAN, 3);
		wr(ADDR_CTRL, 32'h2);
		t0 = cyc;
		wstat(32'h7, 32'h3);
		chk(inr(cyc - t0, 2 * TK - 4, 3 * TK + 8), 1);
		wr(ADDR_CTRL, 32'h4);
		wstat(32'h77, 32'h0);
		$display("test fill limit done");
		k = $urandom_range(1);
		s = $urandom_range(3, 1);
		tim(TI_FILL_FR, 3);
		tim(TI_ACID, s);
		tim(TI_FR_CIRC, 80);
		tim(TI_FR_PURGE, 2);
		wr(ADDR_OPT, 32'h34020 | 32'(k << OPT_FR_DLY));
		wr(ADDR_CTRL, 32'h1);
		wstat(32'h77, 32'h41);
		t0 = cyc;
		chk(32'(outs[1:0]), 32'(water(2)));
		chk(32'(outs[8:2]), 32'h40);
		wout(9'h008, 9'h008, t1);
		chk(inr(t1 - t0, (dly(k) - 1) * TK - 6, dly(k) * TK + 4), 1);
		wout(9'h008, 9'h000, t2);
		chk(inr(t2 - t1, (s - 1) * TK, s * TK + 4), 1);
		chk(32'(milk), 32'h1);
		wstat(32'h7, 32'h5);
		chk(32'(outs[8:5]), 32'hB);
		wstat(32'h70, 32'h50);
		wr(ADDR_CTRL, 32'h4);
		wstat(32'h77, 32'h0);
		$display("test final rinse done");
		results();
	end
endmodule
